// file: verilog/rx_status_pkg.sv
`default_nettype none

package rx_status_pkg;

  // register map, byte addresses
  localparam logic [7:0]  STATUS_OFS     = 8'h00;
  localparam logic [7:0]  CONTROL_OFS    = 8'h04;
  localparam logic [31:0] STATUS_RESET   = 32'h3E00_8000;
  localparam logic [4:0]  NO_ENTRY       = 5'h1F;

  // status bit positions
  localparam int ENTRY_LSB     = 25;
  localparam int CODE_LSB      = 21;
  localparam int BCAST_BIT     = 18;
  localparam int MCAST_BIT     = 17;
  localparam int HALTED_BIT    = 15;
  localparam int GOOD_BIT      = 14;
  localparam int CRC_BIT       = 9;
  localparam int ALIGN_BIT     = 8;
  localparam int IRQ_FLAG_BIT  = 6;
  localparam int CTL_BIT       = 5;
  localparam int LEN_BIT       = 4;

  // control bit positions
  localparam int EN_GOOD_BIT   = 0;
  localparam int EN_CRC_BIT    = 1;
  localparam int EN_ALIGN_BIT  = 2;
  localparam int EN_LEN_BIT    = 3;
  localparam int EN_CTL_BIT    = 4;
  localparam int SHORT_BIT     = 8;
  localparam int FWD_CTL_BIT   = 9;
  localparam int STRIP_BIT     = 10;
  localparam int SOFT_RST_BIT  = 31;

  // frame figures
  localparam logic [15:0] CTL_TYPE       = 16'h8808;
  localparam logic [15:0] SHORT_LEN_MAX  = 16'h002E;
  localparam logic [15:0] MID_LEN_MIN    = 16'h002F;
  localparam logic [15:0] MID_LEN_MAX    = 16'h05DC;
  localparam logic [15:0] FIXED_SIZE     = 16'h0040;
  localparam logic [15:0] OVERHEAD_CRC   = 16'h0012;
  localparam logic [15:0] OVERHEAD_STRIP = 16'h000E;
  localparam logic [15:0] MIN_LEN_LONG   = 16'h0040;
  localparam logic [15:0] MIN_LEN_SHORT  = 16'h000E;
  localparam logic [15:0] RUNT_LEN       = 16'h0006;

  // filter decision codes, bit 3 high means kept
  localparam logic [3:0] TOSS_CTL      = 4'h0;
  localparam logic [3:0] TOSS_SHORT    = 4'h1;
  localparam logic [3:0] TOSS_TBL_NOT  = 4'h2;
  localparam logic [3:0] TOSS_CAM_NOT  = 4'h4;
  localparam logic [3:0] TOSS_NO_MATCH = 4'h6;
  localparam logic [3:0] TOSS_RUNT     = 4'h7;
  localparam logic [3:0] KEEP_ACCEPT   = 4'h8;
  localparam logic [3:0] KEEP_TBL_AND  = 4'hA;
  localparam logic [3:0] KEEP_CAM_AND  = 4'hC;
  localparam logic [3:0] KEEP_MISS_AND = 4'hE;

  typedef struct packed {
    logic [15:0] byte_count;
    logic [15:0] len_type;
    logic        odd_bits;
    logic        crc_ok;
    logic        rx_er;
    logic        other_error;
    logic        dest_recognised;
    logic        is_bcast;
    logic        is_mcast;
    logic        accept_match;
    logic        not_filter;
    logic        and_filter;
    logic        compare_en;
  } frame_info_t;

  typedef struct packed {
    logic strip_crc;
    logic forward_control_frames;
    logic allow_short_packets;
    logic en_ctl;
    logic en_len;
    logic en_align;
    logic checksum_fail_irq_enable;
    logic error_free_irq_enable;
  } ctrl_t;

endpackage

`default_nettype wire

// file: verilog/rx_status.sv
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - misaligned length with bad checksum sets bit 8
// - irq flag bit 6 on enabled condition
// - error-free enable also raises receive irq
// - tossed packet sets flag, no interrupt
// - type 0x8808 recognised sets bit 5
// - length 46 or less: size not 64
// - length 47..1500: size not length+18/14
// - soft reset loads 0x3E008000
// - status cleared at every packet start
// - flags sticky until next packet
// - interrupt only when enable bit set
// - unicast shown by bits 17,18 zero
// - toss codes 0000, 0001, 0111
// - toss codes 0010, 0100, 0110
// - keep codes 1000, 1010
// - keep codes 1100, 1110
// - minimum length 64, or 14 if short
// - first filter hit blocks the later one
// - entry index, all ones on no match
// - decision code in bits 24:21
// - good flag bit 14 when error free
module rx_status (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  // frame events from receive logic
  input  wire logic                       frame_start_i,
  input  wire logic                       frame_end_i,
  input  wire rx_status_pkg::frame_info_t frame_info_i,
  input  wire logic                       tbl_hit_i,
  input  wire logic [4:0]                 tbl_entry_i,
  input  wire logic                       cam_hit_i,
  input  wire logic                       rx_halted_i,
  // status out
  output logic      [31:0]                rx_status_o,
  output logic                            mac_receive_source_bit_o
);

  typedef struct packed {
    logic [31:0]          status;
    rx_status_pkg::ctrl_t ctrl;
    logic                 in_frame;
    logic                 tbl_first;
    logic                 cam_first;
    logic [4:0]           entry;
    logic                 ack;
    logic [31:0]          rdata;
    logic                 irq;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic   bus_req;
  logic   ctrl_write;
  logic   soft_rst;

  assign bus_req    = wb_cyc_i && wb_stb_i && !state_reg.ack;
  assign ctrl_write = bus_req && wb_we_i && (wb_adr_i == rx_status_pkg::CONTROL_OFS);
  assign soft_rst   = ctrl_write && wb_sel_i[3] && wb_dat_i[rx_status_pkg::SOFT_RST_BIT];

  always_comb
  begin
    logic [15:0] min_len;
    logic [15:0] overhead;
    logic        crc_err;
    logic        align_err;
    logic        len_err;
    logic        ctl_seen;
    logic        good;
    logic        irq_cond;
    logic [3:0]  code;
    logic        tbl_m;
    logic        cam_m;
    logic [4:0]  entry;
    logic [31:0] ctrl_word;
    min_len   = state_reg.ctrl.allow_short_packets ? rx_status_pkg::MIN_LEN_SHORT
                                                   : rx_status_pkg::MIN_LEN_LONG;
    overhead  = state_reg.ctrl.strip_crc ? rx_status_pkg::OVERHEAD_STRIP
                                         : rx_status_pkg::OVERHEAD_CRC;
    crc_err   = !frame_info_i.crc_ok || frame_info_i.rx_er;
    align_err = frame_info_i.odd_bits && !frame_info_i.crc_ok;
    len_err   = 1'b0;
    if (frame_info_i.len_type <= rx_status_pkg::SHORT_LEN_MAX)
    begin
      len_err = frame_info_i.byte_count != rx_status_pkg::FIXED_SIZE;
    end
    else if (frame_info_i.len_type <= rx_status_pkg::MID_LEN_MAX)
    begin
      len_err = frame_info_i.byte_count != 16'(frame_info_i.len_type + overhead);
    end
    ctl_seen  = (frame_info_i.len_type == rx_status_pkg::CTL_TYPE)
                && frame_info_i.dest_recognised;
    good      = !crc_err && !align_err && !len_err && !frame_info_i.other_error;
    irq_cond  = (good && state_reg.ctrl.error_free_irq_enable)
                || (crc_err && state_reg.ctrl.checksum_fail_irq_enable)
                || (align_err && state_reg.ctrl.en_align)
                || (len_err && state_reg.ctrl.en_len)
                || (ctl_seen && state_reg.ctrl.en_ctl);
    // a hit arriving in the closing cycle still counts if none came before
    tbl_m = state_reg.tbl_first || (tbl_hit_i && !state_reg.cam_first);
    cam_m = state_reg.cam_first || (cam_hit_i && !tbl_m);
    entry = state_reg.tbl_first ? state_reg.entry
                                : (tbl_m ? tbl_entry_i : rx_status_pkg::NO_ENTRY);
    if ((frame_info_i.len_type == rx_status_pkg::CTL_TYPE)
        && !state_reg.ctrl.forward_control_frames)
    begin
      code = rx_status_pkg::TOSS_CTL;
    end
    else if (frame_info_i.byte_count < min_len)
    begin
      code = (frame_info_i.byte_count >= rx_status_pkg::RUNT_LEN)
             ? rx_status_pkg::TOSS_SHORT : rx_status_pkg::TOSS_RUNT;
    end
    else if (tbl_m && frame_info_i.not_filter)
    begin
      code = rx_status_pkg::TOSS_TBL_NOT;
    end
    else if (cam_m && frame_info_i.not_filter)
    begin
      code = rx_status_pkg::TOSS_CAM_NOT;
    end
    else if (frame_info_i.accept_match)
    begin
      code = rx_status_pkg::KEEP_ACCEPT;
    end
    else if (tbl_m)
    begin
      code = rx_status_pkg::KEEP_TBL_AND;
    end
    else if (cam_m)
    begin
      code = rx_status_pkg::KEEP_CAM_AND;
    end
    else if (frame_info_i.compare_en)
    begin
      code = rx_status_pkg::KEEP_MISS_AND;
    end
    else
    begin
      code = rx_status_pkg::TOSS_NO_MATCH;
    end
    ctrl_word = '0;
    ctrl_word[rx_status_pkg::EN_GOOD_BIT]  = state_reg.ctrl.error_free_irq_enable;
    ctrl_word[rx_status_pkg::EN_CRC_BIT]   = state_reg.ctrl.checksum_fail_irq_enable;
    ctrl_word[rx_status_pkg::EN_ALIGN_BIT] = state_reg.ctrl.en_align;
    ctrl_word[rx_status_pkg::EN_LEN_BIT]   = state_reg.ctrl.en_len;
    ctrl_word[rx_status_pkg::EN_CTL_BIT]   = state_reg.ctrl.en_ctl;
    ctrl_word[rx_status_pkg::SHORT_BIT]    = state_reg.ctrl.allow_short_packets;
    ctrl_word[rx_status_pkg::FWD_CTL_BIT]  = state_reg.ctrl.forward_control_frames;
    ctrl_word[rx_status_pkg::STRIP_BIT]    = state_reg.ctrl.strip_crc;

    state_next     = state_reg;
    state_next.ack = 1'b0;
    state_next.irq = 1'b0;
    state_next.status[rx_status_pkg::HALTED_BIT] = rx_halted_i;

    if (frame_start_i)
    begin
      state_next.status = '0;
      state_next.status[rx_status_pkg::HALTED_BIT] = rx_halted_i;
      state_next.status[rx_status_pkg::ENTRY_LSB +: 5] = rx_status_pkg::NO_ENTRY;
      state_next.in_frame  = 1'b1;
      state_next.tbl_first = 1'b0;
      state_next.cam_first = 1'b0;
      state_next.entry     = rx_status_pkg::NO_ENTRY;
    end
    else if (state_reg.in_frame && !frame_end_i)
    begin
      // the first hit to arrive locks out the other one
      if (tbl_hit_i && !state_reg.tbl_first && !state_reg.cam_first)
      begin
        state_next.tbl_first = 1'b1;
        state_next.entry     = tbl_entry_i;
      end
      else if (cam_hit_i && !state_reg.tbl_first && !state_reg.cam_first)
      begin
        state_next.cam_first = 1'b1;
      end
    end

    if (frame_end_i && !frame_start_i)
    begin
      state_next.in_frame = 1'b0;
      state_next.status[rx_status_pkg::CRC_BIT]   = state_reg.status[rx_status_pkg::CRC_BIT]
                                                  | crc_err;
      state_next.status[rx_status_pkg::ALIGN_BIT] = state_reg.status[rx_status_pkg::ALIGN_BIT]
                                                  | align_err;
      state_next.status[rx_status_pkg::LEN_BIT]   = state_reg.status[rx_status_pkg::LEN_BIT]
                                                  | len_err;
      state_next.status[rx_status_pkg::CTL_BIT]   = state_reg.status[rx_status_pkg::CTL_BIT]
                                                  | ctl_seen;
      state_next.status[rx_status_pkg::GOOD_BIT]  = state_reg.status[rx_status_pkg::GOOD_BIT]
                                                  | good;
      state_next.status[rx_status_pkg::IRQ_FLAG_BIT] =
        state_reg.status[rx_status_pkg::IRQ_FLAG_BIT] | irq_cond;
      state_next.status[rx_status_pkg::BCAST_BIT] = frame_info_i.is_bcast;
      state_next.status[rx_status_pkg::MCAST_BIT] = frame_info_i.is_mcast;
      state_next.status[rx_status_pkg::CODE_LSB +: 4]  = code;
      state_next.status[rx_status_pkg::ENTRY_LSB +: 5] = entry;
      state_next.irq = irq_cond && code[3];
    end

    if (bus_req)
    begin
      state_next.ack   = 1'b1;
      state_next.rdata = '0;
      if (wb_adr_i == rx_status_pkg::STATUS_OFS)
      begin
        state_next.rdata = state_reg.status;
      end
      else if (wb_adr_i == rx_status_pkg::CONTROL_OFS)
      begin
        state_next.rdata = ctrl_word;
      end
    end

    if (ctrl_write && wb_sel_i[0])
    begin
      state_next.ctrl.error_free_irq_enable    = wb_dat_i[rx_status_pkg::EN_GOOD_BIT];
      state_next.ctrl.checksum_fail_irq_enable = wb_dat_i[rx_status_pkg::EN_CRC_BIT];
      state_next.ctrl.en_align                 = wb_dat_i[rx_status_pkg::EN_ALIGN_BIT];
      state_next.ctrl.en_len                   = wb_dat_i[rx_status_pkg::EN_LEN_BIT];
      state_next.ctrl.en_ctl                   = wb_dat_i[rx_status_pkg::EN_CTL_BIT];
    end
    if (ctrl_write && wb_sel_i[1])
    begin
      state_next.ctrl.allow_short_packets    = wb_dat_i[rx_status_pkg::SHORT_BIT];
      state_next.ctrl.forward_control_frames = wb_dat_i[rx_status_pkg::FWD_CTL_BIT];
      state_next.ctrl.strip_crc              = wb_dat_i[rx_status_pkg::STRIP_BIT];
    end

    if (soft_rst)
    begin
      state_next.status    = rx_status_pkg::STATUS_RESET;
      state_next.in_frame  = 1'b0;
      state_next.tbl_first = 1'b0;
      state_next.cam_first = 1'b0;
      state_next.entry     = rx_status_pkg::NO_ENTRY;
      state_next.irq       = 1'b0;
    end
    // reserved bits are never stored
    state_next.status[31:30] = 2'h0;
    state_next.status[16]    = 1'b0;
    state_next.status[13:10] = 4'h0;
    state_next.status[7]     = 1'b0;
    state_next.status[3:0]   = 4'h0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg        <= '0;
      state_reg.status <= rx_status_pkg::STATUS_RESET;
      state_reg.entry  <= rx_status_pkg::NO_ENTRY;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign wb_dat_o                 = state_reg.rdata;
  assign wb_ack_o                 = state_reg.ack;
  assign rx_status_o              = state_reg.status;
  assign mac_receive_source_bit_o = state_reg.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic end_only;
  assign end_only = frame_end_i && !frame_start_i && !soft_rst;

  property p_align;
    end_only && frame_info_i.odd_bits && !frame_info_i.crc_ok
    |=> rx_status_o[rx_status_pkg::ALIGN_BIT];
  endproperty
  a_align: assert property (p_align) else $error("alignment flag missing");

  property p_ctl;
    end_only && frame_info_i.len_type == rx_status_pkg::CTL_TYPE
    && frame_info_i.dest_recognised |=> rx_status_o[rx_status_pkg::CTL_BIT];
  endproperty
  a_ctl: assert property (p_ctl) else $error("control frame flag missing");

  property p_len_short;
    end_only && frame_info_i.len_type <= rx_status_pkg::SHORT_LEN_MAX
    && frame_info_i.byte_count != rx_status_pkg::FIXED_SIZE
    |=> rx_status_o[rx_status_pkg::LEN_BIT];
  endproperty
  a_len_short: assert property (p_len_short) else $error("short length error missing");

  property p_len_mid;
    end_only && frame_info_i.len_type >= rx_status_pkg::MID_LEN_MIN
    && frame_info_i.len_type <= rx_status_pkg::MID_LEN_MAX
    && !state_reg.ctrl.strip_crc && !ctrl_write
    && frame_info_i.byte_count != 16'(frame_info_i.len_type + rx_status_pkg::OVERHEAD_CRC)
    |=> rx_status_o[rx_status_pkg::LEN_BIT];
  endproperty
  a_len_mid: assert property (p_len_mid) else $error("in-range length error missing");

  property p_soft_reset;
    soft_rst |=> rx_status_o == rx_status_pkg::STATUS_RESET
                 && !mac_receive_source_bit_o;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset value wrong");

  property p_start_clear;
    frame_start_i && !soft_rst
    |=> rx_status_o[24:4] == 21'h0 || rx_status_o[24:4] == 21'h0000800;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("status not cleared");

  property p_sticky;
    !frame_start_i && !soft_rst ##1 rx_status_o[rx_status_pkg::CRC_BIT]
    |-> ##1 rx_status_o[rx_status_pkg::CRC_BIT] || $past(frame_start_i) || $past(soft_rst);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped early");

  property p_irq_cause;
    mac_receive_source_bit_o |-> rx_status_o[rx_status_pkg::IRQ_FLAG_BIT]
                                 && rx_status_o[rx_status_pkg::CODE_LSB + 3]
                                 && $past(frame_end_i);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without kept flag");

  property p_good_irq;
    end_only && !ctrl_write && state_reg.ctrl.error_free_irq_enable
    && frame_info_i.crc_ok && !frame_info_i.rx_er && !frame_info_i.odd_bits
    && !frame_info_i.other_error && frame_info_i.len_type > rx_status_pkg::MID_LEN_MAX
    |=> rx_status_o[rx_status_pkg::GOOD_BIT] && rx_status_o[rx_status_pkg::IRQ_FLAG_BIT];
  endproperty
  a_good_irq: assert property (p_good_irq) else $error("good packet irq missing");

  property p_no_enable;
    end_only && !ctrl_write && state_reg.ctrl == '0
    |=> !mac_receive_source_bit_o && !rx_status_o[rx_status_pkg::IRQ_FLAG_BIT];
  endproperty
  a_no_enable: assert property (p_no_enable) else $error("irq with no enable");

  property p_unicast;
    end_only && !frame_info_i.is_bcast && !frame_info_i.is_mcast
    |=> rx_status_o[18:17] == 2'h0;
  endproperty
  a_unicast: assert property (p_unicast) else $error("unicast not shown");

  property p_reserved;
    rx_status_o[31:30] == 2'h0 && !rx_status_o[16] && !rx_status_o[7]
    && rx_status_o[3:0] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  c_kept_irq: cover property (mac_receive_source_bit_o);
  c_tossed: cover property (end_only ##1 rx_status_o[rx_status_pkg::IRQ_FLAG_BIT]
                            && !rx_status_o[rx_status_pkg::CODE_LSB + 3]);
  c_soft_reset: cover property (soft_rst);
  c_race: cover property (state_reg.cam_first && tbl_hit_i);

endmodule

`default_nettype wire

// file: tb/rx_frame_source.sv
`timescale 1ns/1ps
`default_nettype none

// receive-side model: frame start, filter hits, frame end with its summary
module rx_frame_source (
  // clock
  input  wire logic                  clk_i,
  // frame events toward the status block
  output logic                       frame_start_o,
  output logic                       frame_end_o,
  output rx_status_pkg::frame_info_t frame_info_o,
  output logic                       tbl_hit_o,
  output logic [4:0]                 tbl_entry_o,
  output logic                       cam_hit_o
);
  initial
  begin
    frame_start_o = 1'b0;
    frame_end_o   = 1'b0;
    frame_info_o  = '1;
    tbl_hit_o     = 1'b0;
    tbl_entry_o   = 5'h0A;
    cam_hit_o     = 1'b0;
  end

  task automatic start_only;
    @(posedge clk_i);
    frame_start_o <= 1'b1;
    @(posedge clk_i);
    frame_start_o <= 1'b0;
  endtask

  // gap stretches the frame so the block sees slow as well as prompt frames
  task automatic send(input rx_status_pkg::frame_info_t fi, input logic [1:0] hit,
                      input logic [4:0] ent, input int gap);
    start_only();
    tbl_hit_o   <= hit[0];
    cam_hit_o   <= hit[1];
    tbl_entry_o <= ent;
    @(posedge clk_i);
    tbl_hit_o   <= 1'b0;
    cam_hit_o   <= 1'b0;
    tbl_entry_o <= ~ent;
    repeat (gap) @(posedge clk_i);
    frame_end_o  <= 1'b1;
    frame_info_o <= fi;
    @(posedge clk_i);
    frame_end_o  <= 1'b0;
    frame_info_o <= ~fi;
  endtask
endmodule

`default_nettype wire

// file: tb/rx_status_tb.sv
`timescale 1ns/1ps
`default_nettype none

module rx_status_tb;
  logic                       clk_i = 1'b0;
  logic                       rst_i = 1'b1;
  logic                       cyc   = 1'b0;
  logic                       stb   = 1'b0;
  logic                       we    = 1'b0;
  logic [7:0]                 adr   = 8'h00;
  logic [31:0]                dat   = 32'h0;
  logic [31:0]                dat_o;
  logic                       ack;
  logic                       fs;
  logic                       fe;
  rx_status_pkg::frame_info_t fi;
  logic                       ahit;
  logic [4:0]                 aent;
  logic                       chit;
  logic [31:0]                st;
  logic                       pulse;
  logic [31:0]                q;
  int                         errors = 0;
  int                         check_count = 0;

  always #25 clk_i = ~clk_i;

  rx_frame_source src (.clk_i(clk_i), .frame_start_o(fs), .frame_end_o(fe), .frame_info_o(fi),
    .tbl_hit_o(ahit), .tbl_entry_o(aent), .cam_hit_o(chit));

  rx_status dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .frame_start_i(fs), .frame_end_i(fe), .frame_info_i(fi), .tbl_hit_i(ahit),
    .tbl_entry_i(aent), .cam_hit_i(chit), .rx_halted_i(1'b1), .rx_status_o(st),
    .mac_receive_source_bit_o(pulse));

  task automatic report_and_stop;
    $display("mismatches %0d, comparisons %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // classic single wishbone cycle, held until ack is sampled high; the watchdog bounds the wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  function automatic rx_status_pkg::frame_info_t base(input logic [15:0] bc,
                                                      input logic [15:0] lt);
    rx_status_pkg::frame_info_t f;
    f = '0;
    f.byte_count = bc;
    f.len_type   = lt;
    f.crc_ok     = 1'b1;
    return f;
  endfunction

  task automatic frame(input rx_status_pkg::frame_info_t f, input logic [1:0] hit, input int gap);
    src.send(f, hit, 5'h05, gap);
    @(negedge clk_i);
  endtask

  task automatic t_regs;
    wb(1'b0, 8'h00, 32'h0);
    check(q, rx_status_pkg::STATUS_RESET);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    check(q, 32'h3E00_8000);
    wb(1'b0, 8'h10, 32'h0);
    check(q, 32'h0);
  endtask

  task automatic t_good;
    rx_status_pkg::frame_info_t f;
    f = base(16'h0040, 16'h002E);
    f.accept_match = 1'b1;
    f.is_mcast     = 1'b1;
    wb(1'b1, 8'h04, 32'h0000_001F);
    frame(f, 2'b00, 4);
    check(st, 32'h3F02_C040);
    check({31'h0, pulse}, 32'h1);
    repeat (3) @(negedge clk_i);
    check(st, 32'h3F02_C040);
    check({31'h0, pulse}, 32'h0);
    f.is_mcast = 1'b0;
    wb(1'b1, 8'h04, 32'h0);
    frame(f, 2'b00, 0);
    check(st, 32'h3F00_C000);
    check({31'h0, pulse}, 32'h0);
  endtask

  task automatic t_align;
    rx_status_pkg::frame_info_t f;
    f = base(16'h0040, 16'h002E);
    f.accept_match = 1'b1;
    f.odd_bits     = 1'b1;
    f.crc_ok       = 1'b0;
    wb(1'b1, 8'h04, 32'h0000_0004);
    frame(f, 2'b00, 0);
    check(st, 32'h3F00_8340);
    check({31'h0, pulse}, 32'h1);
    f.odd_bits = 1'b0;
    f.crc_ok   = 1'b1;
    f.rx_er    = 1'b1;
    wb(1'b1, 8'h04, 32'h0000_0002);
    frame(f, 2'b00, 0);
    check(st, 32'h3F00_8240);
    check({31'h0, pulse}, 32'h1);
  endtask

  task automatic t_ctl;
    rx_status_pkg::frame_info_t f;
    f = base(16'h0040, rx_status_pkg::CTL_TYPE);
    f.accept_match    = 1'b1;
    f.dest_recognised = 1'b1;
    wb(1'b1, 8'h04, 32'h0000_0001);
    frame(f, 2'b00, 0);
    check(st, 32'h3E00_C060);
    check({31'h0, pulse}, 32'h0);
    wb(1'b1, 8'h04, 32'h0000_0210);
    frame(f, 2'b00, 0);
    check(st, 32'h3F00_C060);
    check({31'h0, pulse}, 32'h1);
  endtask

  task automatic len_case(input logic [15:0] bc, input logic [15:0] lt, input logic e);
    rx_status_pkg::frame_info_t f;
    f = base(bc, lt);
    f.accept_match = 1'b1;
    frame(f, 2'b00, 0);
    check({31'h0, st[rx_status_pkg::LEN_BIT]}, {31'h0, e});
  endtask

  task automatic t_len;
    wb(1'b1, 8'h04, 32'h0000_0008);
    len_case(16'h003C, 16'h002E, 1'b1);
    len_case(16'h0040, 16'h002E, 1'b0);
    len_case(16'h0076, 16'h0064, 1'b0);
    len_case(16'h0072, 16'h0064, 1'b1);
    wb(1'b1, 8'h04, 32'h0000_0408);
    len_case(16'h0072, 16'h0064, 1'b0);
    len_case(16'h0041, 16'h002F, 1'b1);
    len_case(16'h05EA, 16'h05DC, 1'b0);
  endtask

  // fl = {not_filter, and_filter, compare_en, accept_match}
  task automatic code_case(input logic [15:0] bc, input logic [15:0] lt, input logic [3:0] fl,
                           input logic [1:0] hit, input logic [3:0] e);
    rx_status_pkg::frame_info_t f;
    f = base(bc, lt);
    {f.not_filter, f.and_filter, f.compare_en, f.accept_match} = fl;
    frame(f, hit, 0);
    check({28'h0, st[24:21]}, {28'h0, e});
    if (!hit[1])
      check({27'h0, st[29:25]}, {27'h0, hit[0] ? 5'h05 : rx_status_pkg::NO_ENTRY});
  endtask

  task automatic t_codes;
    wb(1'b1, 8'h04, 32'h0);
    code_case(16'h0040, 16'h8808, 4'b0001, 2'b00, 4'h0);
    code_case(16'h000A, 16'h002E, 4'b0001, 2'b00, 4'h1);
    code_case(16'h0004, 16'h002E, 4'b0001, 2'b00, 4'h7);
    code_case(16'h0040, 16'h002E, 4'b1000, 2'b01, 4'h2);
    code_case(16'h0040, 16'h002E, 4'b1000, 2'b10, 4'h4);
    code_case(16'h0040, 16'h002E, 4'b0100, 2'b00, 4'h6);
    code_case(16'h0040, 16'h002E, 4'b0001, 2'b00, 4'h8);
    code_case(16'h0040, 16'h002E, 4'b0100, 2'b01, 4'hA);
    code_case(16'h0040, 16'h002E, 4'b0100, 2'b10, 4'hC);
    code_case(16'h0040, 16'h002E, 4'b0110, 2'b00, 4'hE);
    code_case(16'h0040, 16'h002E, 4'b0100, 2'b11, 4'hA);
    code_case(16'h003F, 16'h002E, 4'b0001, 2'b00, 4'h1);
    wb(1'b1, 8'h04, 32'h0000_0100);
    code_case(16'h000E, 16'h002E, 4'b0001, 2'b00, 4'h8);
    code_case(16'h000D, 16'h002E, 4'b0001, 2'b00, 4'h1);
  endtask

  task automatic t_clear;
    src.start_only();
    @(negedge clk_i);
    check(st, 32'h3E00_8000);
    frame(base(16'h003C, 16'h002E), 2'b00, 0);
    wb(1'b1, 8'h04, 32'h8000_0000);
    @(negedge clk_i);
    check(st, rx_status_pkg::STATUS_RESET);
    wb(1'b0, 8'h04, 32'h0);
    check(q, 32'h0);
  endtask

  initial
  begin
    repeat (5000) @(posedge clk_i);
    errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_good();
    t_align();
    t_ctl();
    t_len();
    t_codes();
    t_clear();
    report_and_stop();
  end
endmodule

`default_nettype wire
